// ===== dv/lrq_decoder_bench.sv
// Self-checking bench for the rotation decoder.
// Needs the tank pair model and the port checker.
`timescale 1ns/1ps
`default_nettype none
module lrq_decoder_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic undersample_clear = 1'b0;
    logic [15:0] pulse_cycles = 16'h0000;
    logic [15:0] osc_expect = 16'h0004;
    logic [15:0] window_cycles = 16'h0258;
    // Short sampling periods keep the run brief
    logic [31:0] sample_cycles = 32'h0000_0bb8;
    logic [31:0] fast_cycles = 32'h0000_0960;
    logic [1:0] pos_q = 2'h0;
    logic [1:0] prev = 2'h0;
    logic [15:0] fw = 16'h0000;
    logic [15:0] bw = 16'h0000;
    logic err = 1'b0;
    logic [31:0] rnd = 32'h0000_0057;
    logic undersample_err, fast_mode, step_fwd, step_bwd;
    logic [1:0] oscillation_comparator, charge_n, sensor_pair_code, damped;
    logic [15:0] forward_step_count, backward_step_count;
    logic [15:0] net_rotation_count, edge_interval_timer;
    logic [34:0] exp_q[$];
    logic [34:0] e;
    logic [1:0] seq [9] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h2,
        2'h0, 2'h2, 2'h1, 2'h0};
    int bad_count = 0;
    int check_count = 0;
    assign damped = {pos_q[0], pos_q[1]};
    lrq_decoder dut_u (.clk, .rst, .pulse_cycles, .osc_expect,
        .window_cycles, .undersample_clear, .sample_cycles, .fast_cycles,
        .oscillation_comparator,
        .charge_n, .sensor_pair_code, .forward_step_count,
        .backward_step_count, .net_rotation_count, .edge_interval_timer,
        .undersample_err, .fast_mode, .step_fwd, .step_bwd);
    lrq_tank_pair tank_u (.charge_n, .damped,
        .osc_out(oscillation_comparator));
    function automatic logic [1:0] nxt(input logic [1:0] c);
        return {c[0], ~c[1]};
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input string what, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    // Ceiling: nine short sampling periods with ample margin
    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 9; k++) begin
            pos_q <= seq[k];
            if (k > 0 && seq[k] == nxt(prev))
                fw = fw + 16'h0001;
            else if (k > 0 && prev == nxt(seq[k]))
                bw = bw + 16'h0001;
            else if (k > 0 && seq[k] == ~prev)
                err = 1'b1;
            exp_q.push_back({seq[k], fw, bw, err});
            @(posedge charge_n[1]);
            repeat (700) @(posedge clk);
            prev = seq[k];
            rnd = xs(rnd);
            pulse_cycles <= {13'h0, rnd[2:0]};
        end
        undersample_clear <= 1'b1;
        @(posedge clk);
        undersample_clear <= 1'b0;
        repeat (2) @(posedge clk);
        check("clear", {14'h0, undersample_err, fast_mode}, 16'h0);
        end_sim();
    end
    initial begin
        @(negedge rst);
        forever begin
            @(posedge charge_n[1]);
            repeat (620) @(posedge clk);
            e = exp_q.pop_front();
            check("code", {14'h0, sensor_pair_code},
                {14'h0, e[34:33]});
            check("fwd", forward_step_count, e[32:17]);
            check("bwd", backward_step_count, e[16:1]);
            check("net", net_rotation_count, e[32:17] - e[16:1]);
            check("err", {14'h0, undersample_err, fast_mode},
                {14'h0, e[0], e[0]});
            check("tmr", {15'h0, edge_interval_timer === 16'h0002},
                {15'h0, e[33]});
            check("tick", {15'h0, edge_interval_timer[0]}, 16'h0000);
        end
    end
endmodule // lrq_decoder_bench
bind lrq_decoder lrq_decoder_props props_u (.clk, .rst, .pulse_cycles,
    .charge_n, .forward_step_count, .backward_step_count,
    .net_rotation_count, .edge_interval_timer, .undersample_err,
    .fast_mode, .step_fwd,
    .step_bwd);
`default_nettype wire

// ===== dv/lrq_decoder_props.sv
// Port checker for the rotation decoder.
// Bound from the bench; one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module lrq_decoder_props (
    // Clock, reset, settings
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] pulse_cycles,
    // Sensors and results
    input wire logic [1:0] charge_n,
    input wire logic [15:0] forward_step_count,
    input wire logic [15:0] backward_step_count,
    input wire logic [15:0] net_rotation_count,
    input wire logic [15:0] edge_interval_timer,
    input wire logic undersample_err,
    input wire logic fast_mode,
    input wire logic step_fwd,
    input wire logic step_bwd
);
    logic [15:0] low_q;
    // Low cycles of the first charge switch
    always @(posedge clk or posedge rst) begin
        if (rst)
            low_q <= 16'h0000;
        else if (charge_n[0])
            low_q <= 16'h0000;
        else
            low_q <= low_q + 16'h0001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s1_done; $rose(charge_n[0]); endsequence
    sequence s2_start; ##[1:1000] $fell(charge_n[1]); endsequence
    step_excl_a: assert property (!(step_fwd && step_bwd))
        else $error("both step pulses");
    fwd_count_a: assert property (step_fwd |->
        forward_step_count == $past(forward_step_count) + 16'h0001)
        else $error("forward count not stepped");
    bwd_count_a: assert property (step_bwd |->
        backward_step_count == $past(backward_step_count) + 16'h0001)
        else $error("backward count not stepped");
    count_hold_a: assert property (!step_fwd && !step_bwd |->
        $stable(forward_step_count) && $stable(backward_step_count))
        else $error("count moved without step");
    net_diff_a: assert property (s1_done |->
        net_rotation_count == forward_step_count - backward_step_count)
        else $error("net count wrong");
    pulse_len_a: assert property (s1_done |->
        low_q == ((pulse_cycles == 16'h0000) ? 16'h0019 : pulse_cycles))
        else $error("charge pulse length wrong");
    sensor_order_a: assert property (s1_done |-> s2_start)
        else $error("second sensor late");
    err_fast_a: assert property ($rose(undersample_err) |-> fast_mode)
        else $error("fast sampling not entered");
    timer_even_a: assert property (!edge_interval_timer[0])
        else $error("timer result not in double ticks");
endmodule // lrq_decoder_props
`default_nettype wire

// ===== dv/lrq_tank_pair.sv
// Two tank sensors behind their charge switches.
// Ringing starts as a charge pulse ends; idle output low.
`timescale 1ns/1ps
`default_nettype none
module lrq_tank_pair (
    // From the decoder (charge_n) and the bench (damped)
    input wire logic [1:0] charge_n,
    input wire logic [1:0] damped,
    // To the decoder
    output var logic [1:0] osc_out
);
    for (genvar i = 0; i < 2; i++) begin : g_tank
        initial begin
            osc_out[i] = 1'b0;
            forever begin
                // Needs a real low pulse; reset's x-to-1 is no charge
                @(negedge charge_n[i]);
                @(posedge charge_n[i]);
                // Metal rings out early; 833 kHz stays under 1 MHz
                repeat (damped[i] ? 2 : 12) begin
                    #600 osc_out[i] = 1'b1;
                    #600 osc_out[i] = 1'b0;
                end
            end
        end
    end
endmodule // lrq_tank_pair
`default_nettype wire

// ===== hw/lrq_decoder.v
// Rotation quadrature decoder with two inductive tank sensors.
// Assumes comparator outputs are async pins; charge switches driven low.
`timescale 1ns/1ps
`default_nettype none
`include "lrq_defs.vh"

module lrq_decoder (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Settings
    input wire [15:0] pulse_cycles,
    input wire [15:0] osc_expect,
    input wire [15:0] window_cycles,
    input wire undersample_clear,
    // Sampling periods in clocks; zero selects the default
    input wire [31:0] sample_cycles,
    input wire [31:0] fast_cycles,
    // Tank sensors
    input wire [1:0] oscillation_comparator,
    output reg [1:0] charge_n,
    // Results
    output reg [1:0] sensor_pair_code,
    output reg [15:0] forward_step_count,
    output reg [15:0] backward_step_count,
    output reg [15:0] net_rotation_count,
    output reg [15:0] edge_interval_timer,
    output reg undersample_err,
    output reg fast_mode,
    output reg step_fwd,
    output reg step_bwd
);

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_PULSE = 3'd1;
    localparam [2:0] ST_COUNT = 3'd2;
    localparam [2:0] ST_DECODE = 3'd3;

    localparam [31:0] SAMPLE_CYC = `LRQ_SAMPLE_CYC;
    localparam [31:0] FAST_CYC = `LRQ_FAST_CYC;
    localparam [31:0] PULSE_FULL = `LRQ_PULSE_CYC;
    localparam [31:0] WINDOW_FULL = `LRQ_WINDOW_CYC;
    localparam [15:0] PULSE_CYC = PULSE_FULL[15:0];
    localparam [15:0] WINDOW_CYC = WINDOW_FULL[15:0];
    localparam [15:0] OSC_EXPECT = `LRQ_OSC_EXPECT;

    // Zero setting falls back to the built-in default
    function [15:0] pick16;
        input [15:0] val;
        input [15:0] dflt;
        begin
            pick16 = (val == 16'h0000) ? dflt : val;
        end
    endfunction

    function [31:0] pick32;
        input [31:0] val;
        input [31:0] dflt;
        begin
            pick32 = (val == 32'h0000_0000) ? dflt : val;
        end
    endfunction

    // Position index along the forward sequence
    function [1:0] pos_index;
        input [1:0] code;
        begin
            case (code)
                `LRQ_POS_ZERO: pos_index = 2'd0;
                `LRQ_POS_ONE: pos_index = 2'd1;
                `LRQ_POS_TWO: pos_index = 2'd2;
                default: pos_index = 2'd3;
            endcase
        end
    endfunction

    // Two-flop synchronisers for the comparator pins
    reg [1:0] cmp_meta_q;
    reg [1:0] cmp_sync_q;
    reg [1:0] cmp_prev_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cmp_meta_q <= 2'b00;
            cmp_sync_q <= 2'b00;
            cmp_prev_q <= 2'b00;
        end else begin
            cmp_meta_q <= oscillation_comparator;
            cmp_sync_q <= cmp_meta_q;
            cmp_prev_q <= cmp_sync_q;
        end
    end

    reg [2:0] state_q;
    reg sel_q;
    reg phase_q;
    reg [31:0] period_q;
    reg [15:0] cnt_q;
    reg [15:0] osc_q;
    reg [15:0] ticks_q;
    reg [1:0] pair_q;
    reg [1:0] prev_q;
    reg started_q;

    wire cur_cmp = sel_q ? cmp_sync_q[1] : cmp_sync_q[0];
    wire old_cmp = sel_q ? cmp_prev_q[1] : cmp_prev_q[0];
    // One full oscillation per rising crossing of the threshold
    wire rise = cur_cmp & ~old_cmp;
    wire [1:0] diff = pos_index(pair_q) - pos_index(prev_q);
    wire [31:0] period_lim = fast_mode ? pick32(fast_cycles, FAST_CYC) :
        pick32(sample_cycles, SAMPLE_CYC);
    wire period_wrap = (period_q >= period_lim - 32'd1);
    wire [15:0] pulse_len = pick16(pulse_cycles, PULSE_CYC);
    wire [15:0] window_len = pick16(window_cycles, WINDOW_CYC);
    wire [15:0] osc_need = pick16(osc_expect, OSC_EXPECT);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            sel_q <= 1'b0;
            phase_q <= 1'b0;
            period_q <= 32'h0000_0000;
            cnt_q <= 16'h0000;
            osc_q <= 16'h0000;
            ticks_q <= 16'h0000;
            pair_q <= 2'b00;
            prev_q <= 2'b00;
            started_q <= 1'b0;
            charge_n <= 2'b11;
            sensor_pair_code <= 2'b00;
            forward_step_count <= `LRQ_CNT_RESET;
            backward_step_count <= `LRQ_CNT_RESET;
            net_rotation_count <= `LRQ_CNT_RESET;
            edge_interval_timer <= 16'h0000;
            undersample_err <= 1'b0;
            fast_mode <= 1'b0;
            step_fwd <= 1'b0;
            step_bwd <= 1'b0;
        end else begin
            // Phase restarts with the period, so a start always lands
            phase_q <= period_wrap ? 1'b0 : ~phase_q;
            step_fwd <= 1'b0;
            step_bwd <= 1'b0;
            if (undersample_clear) begin
                undersample_err <= 1'b0;
                fast_mode <= 1'b0;
            end
            period_q <= period_wrap ? 32'h0000_0000 : period_q + 32'd1;
            case (state_q)
                ST_IDLE: begin
                    // One charge per sensor each sampling period
                    if (period_q == 32'h0000_0000 && !phase_q) begin
                        state_q <= ST_PULSE;
                        sel_q <= 1'b0;
                        cnt_q <= 16'h0000;
                    end
                end
                ST_PULSE: begin
                    charge_n[sel_q] <= 1'b0;
                    cnt_q <= cnt_q + 16'h0001;
                    // Switch stays low for exactly pulse_len clocks
                    if (cnt_q >= pulse_len) begin
                        charge_n <= 2'b11;
                        state_q <= ST_COUNT;
                        cnt_q <= 16'h0000;
                        osc_q <= 16'h0000;
                        ticks_q <= 16'h0000;
                    end
                end
                ST_COUNT: begin
                    cnt_q <= cnt_q + 16'h0001;
                    // Two ticks per clock: both-edge scale, one-clock resolution
                    ticks_q <= ticks_q + 16'h0002;
                    if (rise)
                        osc_q <= osc_q + 16'h0001;
                    if (rise && osc_q + 16'h0001 >= osc_need) begin
                        // Expected count reached: undamped
                        pair_q[~sel_q] <= `LRQ_UNDAMPED;
                        edge_interval_timer <= ticks_q + 16'h0002;
                        cnt_q <= 16'h0000;
                        sel_q <= 1'b1;
                        state_q <= sel_q ? ST_DECODE : ST_PULSE;
                    end else if (cnt_q + 16'h0001 >= window_len) begin
                        pair_q[~sel_q] <= `LRQ_DAMPED;
                        edge_interval_timer <= `LRQ_TMR_ERROR;
                        cnt_q <= 16'h0000;
                        sel_q <= 1'b1;
                        state_q <= sel_q ? ST_DECODE : ST_PULSE;
                    end
                end
                ST_DECODE: begin
                    state_q <= ST_IDLE;
                    sensor_pair_code <= pair_q;
                    prev_q <= pair_q;
                    started_q <= 1'b1;
                    // First sample only seeds the previous code
                    if (started_q) begin
                        case (diff)
                            2'd1: begin
                                forward_step_count <=
                                    forward_step_count + 16'h0001;
                                net_rotation_count <=
                                    forward_step_count + 16'h0001 -
                                    backward_step_count;
                                step_fwd <= 1'b1;
                            end
                            2'd3: begin
                                backward_step_count <=
                                    backward_step_count + 16'h0001;
                                net_rotation_count <= forward_step_count -
                                    backward_step_count - 16'h0001;
                                step_bwd <= 1'b1;
                            end
                            2'd2: begin
                                // Set wins over a same-cycle clear
                                undersample_err <= 1'b1;
                                fast_mode <= 1'b1;
                            end
                            default: begin
                                net_rotation_count <= net_rotation_count;
                            end
                        endcase
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // lrq_decoder

`default_nettype wire

// ===== hw/lrq_defs.vh
// Constants for the rotation quadrature decoder.
// Included by hw/lrq_decoder.v; definitions only.
`ifndef LRQ_DEFS_VH
`define LRQ_DEFS_VH

// Clock period in picoseconds (100 MHz)
`define LRQ_CLK_PS 10000
// Charge pulse on-time, ns, and its cycle count (rounded up)
`define LRQ_PULSE_NS 250
`define LRQ_PULSE_CYC ((`LRQ_PULSE_NS * 1000 + `LRQ_CLK_PS - 1) / `LRQ_CLK_PS)
// Measuring window, ns, and cycle count (rounded down)
`define LRQ_WINDOW_NS 39000
`define LRQ_WINDOW_CYC ((`LRQ_WINDOW_NS * 1000) / `LRQ_CLK_PS)
// Sampling period at 100 Hz, ns, and cycle count
`define LRQ_SAMPLE_NS 10000000
`define LRQ_SAMPLE_CYC ((`LRQ_SAMPLE_NS / 1000) * 1000 / (`LRQ_CLK_PS / 1000))
// Fastest sampling period, ns, used after undersampling
`define LRQ_FAST_NS 5000000
`define LRQ_FAST_CYC ((`LRQ_FAST_NS / 1000) * 1000 / (`LRQ_CLK_PS / 1000))
// Expected oscillation count for an undamped sensor
`define LRQ_OSC_EXPECT 16'h0016
// Error result of the edge-interval timer: damped
`define LRQ_TMR_ERROR 16'h0002
// Sensor levels
`define LRQ_UNDAMPED 1'b0
`define LRQ_DAMPED 1'b1
// Sensor pair codes
`define LRQ_POS_ZERO 2'b00
`define LRQ_POS_ONE 2'b01
`define LRQ_POS_TWO 2'b11
`define LRQ_POS_THREE 2'b10
// Counter reset value
`define LRQ_CNT_RESET 16'h0000

`endif
